//--- rtl/seq_out_pkg.sv
// seq_out_pkg: register indices, field layout, reset values for the output router
// assumes a word-wide register port addressed by parameter index
package seq_out_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  // parameter indices, used directly as port addresses
  localparam logic [15:0] ADDR_ALLOC_A = 16'h2016;
  localparam logic [15:0] ADDR_ALLOC_B = 16'h2017;
  localparam logic [15:0] ADDR_ALLOC_C = 16'h2018;
  localparam logic [15:0] ADDR_RSVD_D = 16'h2019;
  localparam logic [15:0] ADDR_RSVD_E = 16'h201A;
  localparam logic [15:0] ADDR_ALLOC_F = 16'h201B;
  // status, interrupt and channel state registers
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h2020;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h2021;
  localparam logic [15:0] ADDR_IRQ_CLEAR = 16'h2022;
  localparam logic [15:0] ADDR_CHAN_STATE = 16'h2023;
  // reset values: brake digit (digit 2 of word a) starts at channel 3
  localparam logic [15:0] RST_ALLOC_A = 16'h0300;
  localparam logic [15:0] RST_ALLOC_B = 16'h0000;
  localparam logic [15:0] RST_ALLOC_C = 16'h0000;
  localparam logic [15:0] RST_ALLOC_F = 16'h0000;
  // writable digit masks; reserved digits read zero
  localparam logic [15:0] MASK_ALLOC_C = 16'h00FF;
  localparam logic [15:0] MASK_ALLOC_F = 16'hFF00;
  // digit field
  localparam int DIGIT_W = 4;
  localparam logic [3:0] CHAN_NONE = 4'h0;
  localparam logic [3:0] CHAN_MAX = 4'h3;
  localparam int NUM_CHAN = 3;
  localparam int NUM_FUNC = 12;
  // function numbers: word a digits 0..3, word b 4..7, word c 8..9, word f 10..11
  localparam int FN_BRAKE = 2;
  localparam int FN_WARN = 3;
  localparam int FN_READY = 8;
  // interrupt status bits
  localparam int IRQ_CONFLICT = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_W = 2;
endpackage

//--- rtl/seq_out_decode.sv
// seq_out_decode: one allocation digit turned into a one-hot channel select
// assumes the digit comes from a register on the same clock
`timescale 1ns/1ps
module seq_out_decode (
  input wire logic [3:0] digit, // allocation digit
  output logic [2:0] chan_sel // one-hot: bit0 channel 1 .. bit2 channel 3
);
  // RULE2 digit picks channel
  always_comb begin
    chan_sel = 3'h0;
    // RULE4 zero leaves function unused
    if (digit != seq_out_pkg::CHAN_NONE && digit <= seq_out_pkg::CHAN_MAX) begin
      chan_sel[digit[1:0] - 2'h1] = 1'b1;
    end
  end
endmodule

//--- rtl/sequence_output_router.sv
// sequence_output_router: allocation registers and routing of sequence functions to three outputs
// assumes a single-cycle register port, one clock, synchronous active-low reset
//
// Notes on behaviour
// RULE1: each function is tied to one fixed digit of one allocation word and only that digit routes it.
// RULE2: a digit of 1 to 3 routes its function to the output channel of that number.
// RULE3: channel 3 drives pins 19/20, channel 2 pins 17/18, channel 1 pins 15/16.
// RULE4: a digit of 0 leaves its function driving no channel.
// RULE5: brake control sits in the third digit of word a, and 3 there puts it on channel 3.
// RULE6: two or more functions on one channel raise a servo warning and are not merged.
// RULE7: the warning-detection function is on whenever any servo warning is present.
// RULE8: the drive-ready function is on only with no fault and servo off.
// RULE9: a channel with no function allocated is held off.
`timescale 1ns/1ps
module sequence_output_router (
  input wire logic clock, // 50 MHz control clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [15:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd_en
  input wire logic [11:0] func_in, // internal function levels (brake, warn, ready from dedicated ports)
  input wire logic brake_cmd, // brake control level
  input wire logic ext_warning, // other servo warnings
  input wire logic drive_fault, // drive fault present
  input wire logic servo_on, // servo on state
  output logic out_pin_15_16, // channel 1 photo-coupler
  output logic out_pin_17_18, // channel 2 photo-coupler
  output logic out_pin_19_20, // channel 3 photo-coupler
  output logic alloc_warning, // servo warning from allocation conflict
  output logic irq // level interrupt
);
  ////////////////////////////////////////////////////////////////////////////
  // allocation and interrupt registers
  logic [15:0] alloc_a_r, alloc_a_nxt;
  logic [15:0] alloc_b_r, alloc_b_nxt;
  logic [15:0] alloc_c_r, alloc_c_nxt;
  logic [15:0] alloc_f_r, alloc_f_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_en_r, irq_en_nxt;
  logic [15:0] rdata_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic conflict_r, conflict_nxt;
  logic irq_r, irq_nxt;
  logic conflict_now;
  logic warn_any;
  logic [2:0] chan_calc;
  logic [11:0] func_lvl;
  logic [3:0] digit [seq_out_pkg::NUM_FUNC];
  logic [2:0] sel [seq_out_pkg::NUM_FUNC];

  // RULE1 fixed digit per function
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      digit[i] = alloc_a_r[i*4 +: 4];
      digit[4+i] = alloc_b_r[i*4 +: 4];
    end
    digit[8] = alloc_c_r[3:0];
    digit[9] = alloc_c_r[7:4];
    digit[10] = alloc_f_r[11:8];
    digit[11] = alloc_f_r[15:12];
  end

  // per-function channel decoders
  genvar g;
  generate
    for (g = 0; g < seq_out_pkg::NUM_FUNC; g++) begin : gen_dec
      seq_out_decode u_dec (
        .digit(digit[g]),
        .chan_sel(sel[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // function levels
  always_comb begin
    func_lvl = func_in;
    // RULE5 brake in third digit
    func_lvl[seq_out_pkg::FN_BRAKE] = brake_cmd;
    // RULE7 warning detection
    func_lvl[seq_out_pkg::FN_WARN] = warn_any;
    // RULE8 ready when idle, no fault
    func_lvl[seq_out_pkg::FN_READY] = ~drive_fault & ~servo_on;
  end

  // warning covers allocation conflict and outside warnings
  assign warn_any = conflict_r | ext_warning;

  ////////////////////////////////////////////////////////////////////////////
  // channel routing and conflict detection
  always_comb begin
    int cnt;
    cnt = 0;
    conflict_now = 1'b0;
    chan_calc = 3'h0;
    for (int c = 0; c < seq_out_pkg::NUM_CHAN; c++) begin
      cnt = 0;
      for (int f = 0; f < seq_out_pkg::NUM_FUNC; f++) begin
        if (sel[f][c]) begin
          cnt = cnt + 1;
          // RULE2 route to numbered channel
          chan_calc[c] = func_lvl[f];
        end
      end
      // RULE6 shared channel flags conflict
      if (cnt > 1) begin
        conflict_now = 1'b1;
        chan_calc[c] = 1'b0;
      end
      // RULE9 idle channel off
      if (cnt == 0) begin
        chan_calc[c] = 1'b0;
      end
    end
    chan_nxt = chan_calc;
    conflict_nxt = conflict_now;
  end

  // routing state: registered channels and conflict flag
  always_ff @(posedge clock) begin
    if (!resetn) begin
      chan_r <= 3'h0;
      conflict_r <= 1'b0;
    end else begin
      chan_r <= chan_nxt;
      conflict_r <= conflict_nxt;
    end
  end

  // RULE3 channel numbers to pin pairs
  a_route_three: assert property (@(posedge clock) disable iff (!resetn) // RULE3
    (digit[4] == 4'h3 && !conflict_now) |=> out_pin_19_20 == $past(func_in[4]))
    else $error("digit 3 not routed to channel 3");
  a_route_one: assert property (@(posedge clock) disable iff (!resetn) // RULE3
    (digit[5] == 4'h1 && !conflict_now) |=> out_pin_15_16 == $past(func_in[5]))
    else $error("digit 1 not routed to channel 1");
  // RULE4 unused digits select nothing
  a_unused_digit: assert property (@(posedge clock) disable iff (!resetn) // RULE4
    (digit[6] == 4'h0 || digit[6] > 4'h3) |-> sel[6] == 3'h0)
    else $error("unused digit selected a channel");
  // RULE1 one channel per function
  a_sel_single: assert property (@(posedge clock) disable iff (!resetn) // RULE1
    $onehot0(sel[7]))
    else $error("function routed to two channels");

  ////////////////////////////////////////////////////////////////////////////
  // register writes, interrupt status, read data
  always_comb begin
    alloc_a_nxt = alloc_a_r;
    alloc_b_nxt = alloc_b_r;
    alloc_c_nxt = alloc_c_r;
    alloc_f_nxt = alloc_f_r;
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    rdata_nxt = 16'h0000;
    if (wr_en) begin
      case (addr)
        seq_out_pkg::ADDR_ALLOC_A: alloc_a_nxt = wdata;
        seq_out_pkg::ADDR_ALLOC_B: alloc_b_nxt = wdata;
        seq_out_pkg::ADDR_ALLOC_C: alloc_c_nxt = wdata & seq_out_pkg::MASK_ALLOC_C;
        seq_out_pkg::ADDR_ALLOC_F: alloc_f_nxt = wdata & seq_out_pkg::MASK_ALLOC_F;
        seq_out_pkg::ADDR_IRQ_ENABLE: irq_en_nxt = wdata[1:0];
        seq_out_pkg::ADDR_IRQ_CLEAR: irq_stat_nxt = irq_stat_r & ~wdata[1:0];
        default: ;
      endcase
    end
    // set wins over clear: conflict on its rising edge, warning on its level
    if (conflict_now && !conflict_r) begin
      irq_stat_nxt[seq_out_pkg::IRQ_CONFLICT] = 1'b1;
    end
    if (warn_any) begin
      irq_stat_nxt[seq_out_pkg::IRQ_WARN] = 1'b1;
    end
    if (rd_en) begin
      case (addr)
        seq_out_pkg::ADDR_ALLOC_A: rdata_nxt = alloc_a_r;
        seq_out_pkg::ADDR_ALLOC_B: rdata_nxt = alloc_b_r;
        seq_out_pkg::ADDR_ALLOC_C: rdata_nxt = alloc_c_r;
        seq_out_pkg::ADDR_ALLOC_F: rdata_nxt = alloc_f_r;
        seq_out_pkg::ADDR_IRQ_STATUS: rdata_nxt = {14'h0000, irq_stat_r};
        seq_out_pkg::ADDR_IRQ_ENABLE: rdata_nxt = {14'h0000, irq_en_r};
        seq_out_pkg::ADDR_CHAN_STATE: rdata_nxt = {12'h000, conflict_r, chan_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  // allocation words
  always_ff @(posedge clock) begin
    if (!resetn) begin
      alloc_a_r <= seq_out_pkg::RST_ALLOC_A;
      alloc_b_r <= seq_out_pkg::RST_ALLOC_B;
      alloc_c_r <= seq_out_pkg::RST_ALLOC_C;
      alloc_f_r <= seq_out_pkg::RST_ALLOC_F;
    end else begin
      alloc_a_r <= alloc_a_nxt;
      alloc_b_r <= alloc_b_nxt;
      alloc_c_r <= alloc_c_nxt;
      alloc_f_r <= alloc_f_nxt;
    end
  end

  // RULE1 reserved digits stay zero
  a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn) // RULE1
    alloc_c_r[15:8] == 8'h00 && alloc_f_r[7:0] == 8'h00)
    else $error("reserved digit held a value");

  // interrupt status, enable and level output
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_stat_r <= 2'h0;
      irq_en_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
    end
  end

  // RULE6 conflict sets sticky status
  a_conflict_stat: assert property (@(posedge clock) disable iff (!resetn) // RULE6
    (conflict_now && !conflict_r) |=> irq_stat_r[seq_out_pkg::IRQ_CONFLICT])
    else $error("conflict did not set status");
  a_status_clear: assert property (@(posedge clock) disable iff (!resetn) // RULE6
    (wr_en && addr == seq_out_pkg::ADDR_IRQ_CLEAR && wdata[0] && !(conflict_now && !conflict_r))
    |=> !irq_stat_r[seq_out_pkg::IRQ_CONFLICT])
    else $error("status clear ignored");
  // RULE7 warning sets status
  a_warn_stat: assert property (@(posedge clock) disable iff (!resetn) // RULE7
    warn_any |=> irq_stat_r[seq_out_pkg::IRQ_WARN])
    else $error("warning did not set status");
  // interrupt level follows enabled status
  a_irq_level: assert property (@(posedge clock) disable iff (!resetn) // RULE6
    irq == |(irq_stat_r & irq_en_r))
    else $error("interrupt level disagrees with status");

  // read data stands for one cycle only
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // read data is zero without a read
  a_rdata_idle: assert property (@(posedge clock) disable iff (!resetn) // RULE1
    !rd_en |=> rdata == 16'h0000)
    else $error("read data without a read");

  // RULE3 channel to pin pairs
  assign out_pin_15_16 = chan_r[0];
  assign out_pin_17_18 = chan_r[1];
  assign out_pin_19_20 = chan_r[2];
  assign alloc_warning = conflict_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_brake_ch3: assert property (@(posedge clock) disable iff (!resetn) // RULE5
    (alloc_a_r[11:8] == 4'h3 && alloc_a_r[15:12] != 4'h3 && alloc_a_r[7:4] != 4'h3 && alloc_a_r[3:0] != 4'h3
     && alloc_b_r == 16'h0000 && alloc_c_r == 16'h0000 && alloc_f_r == 16'h0000)
    |=> out_pin_19_20 == $past(brake_cmd))
    else $error("brake not on channel 3");
  a_zero_off: assert property (@(posedge clock) disable iff (!resetn) // RULE4
    (alloc_a_r == 16'h0000 && alloc_b_r == 16'h0000 && alloc_c_r == 16'h0000 && alloc_f_r == 16'h0000)
    |=> chan_r == 3'h0)
    else $error("unallocated function drove a channel");
  a_idle_off: assert property (@(posedge clock) disable iff (!resetn) // RULE9
    !(sel[0][0] | sel[1][0] | sel[2][0] | sel[3][0] | sel[4][0] | sel[5][0] | sel[6][0] | sel[7][0]
      | sel[8][0] | sel[9][0] | sel[10][0] | sel[11][0]) |=> !out_pin_15_16)
    else $error("idle channel 1 driven");
  a_conflict_warn: assert property (@(posedge clock) disable iff (!resetn) // RULE6
    conflict_now |=> alloc_warning)
    else $error("conflict without warning");
  a_conflict_off: assert property (@(posedge clock) disable iff (!resetn) // RULE6
    (sel[2][2] && sel[3][2]) |=> !out_pin_19_20)
    else $error("shared channel merged functions");
  a_warn_func: assert property (@(posedge clock) disable iff (!resetn) // RULE7
    (ext_warning && sel[seq_out_pkg::FN_WARN] == 3'h1 && !conflict_now) |=> out_pin_15_16)
    else $error("warning output missing");
  a_ready_func: assert property (@(posedge clock) disable iff (!resetn) // RULE8
    (sel[seq_out_pkg::FN_READY] == 3'h2 && !conflict_now && (drive_fault || servo_on)) |=> !out_pin_17_18)
    else $error("ready asserted while faulted or on");
  a_ready_on: assert property (@(posedge clock) disable iff (!resetn) // RULE8
    (sel[seq_out_pkg::FN_READY] == 3'h2 && !conflict_now && !drive_fault && !servo_on) |=> out_pin_17_18)
    else $error("ready missing while idle and healthy");
  a_route_two: assert property (@(posedge clock) disable iff (!resetn) // RULE2
    (digit[0] == 4'h2 && !conflict_now) |=> out_pin_17_18 == $past(func_in[0]))
    else $error("digit 2 not routed to channel 2");
  a_alloc_word: assert property (@(posedge clock) disable iff (!resetn) // RULE1
    (wr_en && addr == seq_out_pkg::ADDR_ALLOC_B) |=> alloc_b_r == $past(wdata))
    else $error("allocation word not stored");
  c_conflict: cover property (@(posedge clock) disable iff (!resetn) $rose(alloc_warning));
  c_brake: cover property (@(posedge clock) disable iff (!resetn) $rose(out_pin_19_20));
  c_irq: cover property (@(posedge clock) disable iff (!resetn) $rose(irq));
  c_ready_pin: cover property (@(posedge clock) disable iff (!resetn)
    (sel[seq_out_pkg::FN_READY] == 3'h2) ##1 out_pin_17_18);
  c_warn_pin: cover property (@(posedge clock) disable iff (!resetn)
    (ext_warning && sel[seq_out_pkg::FN_WARN] == 3'h1) ##1 out_pin_15_16);
endmodule

//--- dv/host_model.sv
// host_model: host controller input stage reading the three photo-coupler outputs
// assumes registered output levels, high = coupler on
`timescale 1ns/1ps
module host_model (
  input wire logic clock, // router clock
  input wire logic out_pin_15_16, // channel 1
  input wire logic out_pin_17_18, // channel 2
  input wire logic out_pin_19_20, // channel 3
  output logic [2:0] seen_r // sampled channels, bit0 channel 1
);
  // host input port samples the couplers once a cycle
  always_ff @(posedge clock) begin
    seen_r <= {out_pin_19_20, out_pin_17_18, out_pin_15_16};
  end
endmodule

//--- dv/sequence_output_router_bench.sv
// sequence_output_router_bench: random and corner checks of output allocation
// assumes one 50 MHz clock and the host model as coupler reader
`timescale 1ns/1ps
module sequence_output_router_bench;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [11:0] func_in = 12'h000;
  logic brake_cmd = 1'b0;
  logic ext_warning = 1'b0;
  logic drive_fault = 1'b0;
  logic servo_on = 1'b1;
  logic [15:0] rdata;
  logic p1, p2, p3, alloc_warning, irq;
  logic [2:0] seen_r;
  logic [15:0] seed = 16'h0018;
  logic [15:0] r [5];
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  //////////////////////////////////////////////////////////////
  initial begin
    forever #10 clock = ~clock;
  end
  sequence_output_router i_sequence_output_router (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .func_in(func_in), .brake_cmd(brake_cmd),
    .ext_warning(ext_warning), .drive_fault(drive_fault), .servo_on(servo_on), .out_pin_15_16(p1),
    .out_pin_17_18(p2), .out_pin_19_20(p3), .alloc_warning(alloc_warning), .irq(irq));
  host_model i_host_model (.clock(clock), .out_pin_15_16(p1), .out_pin_17_18(p2), .out_pin_19_20(p3),
    .seen_r(seen_r));
  //////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected {conflict, channels} from allocation words and levels
  function automatic logic [3:0] expect_out(input logic [15:0] a, b, c, f);
    logic [47:0] w;
    logic [11:0] lv;
    logic [2:0] o;
    logic [3:0] d;
    int n [3];
    w = {f[15:8], c[7:0], b, a};
    lv = func_in;
    lv[2] = brake_cmd;
    lv[8] = !drive_fault && !servo_on;
    o = 3'h0;
    n = '{0, 0, 0};
    for (int i = 0; i < 12; i++) begin
      d = w[4*i +: 4];
      if (d inside {[1:3]}) n[d-1]++;
    end
    lv[3] = ext_warning || n[0] > 1 || n[1] > 1 || n[2] > 1;
    for (int i = 0; i < 12; i++) begin
      d = w[4*i +: 4];
      if (d inside {[1:3]}) o[d-1] = o[d-1] | lv[i];
    end
    for (int k = 0; k < 3; k++) if (n[k] > 1) o[k] = 1'b0;
    return {n[0] > 1 || n[1] > 1 || n[2] > 1, o};
  endfunction
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    check(name, exp, rdata);
  endtask
  // program four words and levels, let routing settle, compare outputs
  task automatic apply(input logic [15:0] a, b, c, f, input logic [11:0] fi, input logic [3:0] ctl);
    logic [3:0] e;
    @(posedge clock);
    func_in <= fi;
    {brake_cmd, ext_warning, drive_fault, servo_on} <= ctl;
    wr(16'h2016, a);
    wr(16'h2017, b);
    wr(16'h2018, c);
    wr(16'h201B, f);
    tick(4);
    e = expect_out(a, b, c, f);
    check("pins", {13'h0000, e[2:0]}, {13'h0000, p3, p2, p1});
    check("host_seen", {13'h0000, e[2:0]}, {13'h0000, seen_r});
    check("alloc_warning", {15'h0000, e[3]}, {15'h0000, alloc_warning});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(16'h2016, 16'h0300, "alloc_a");
    rd(16'h2017, 16'h0000, "alloc_b");
    rd(16'h2018, 16'h0000, "alloc_c");
    rd(16'h201B, 16'h0000, "alloc_f");
    $display("test reset_values done");
    apply(16'h0300, 16'h0000, 16'h0000, 16'h0000, 12'h000, 4'h9);
    for (int v = 0; v < 5; v++) apply({12'h000, v[3:0]}, 16'h0000, 16'h0000, 16'h0000, 12'h001, 4'h1);
    apply(16'h3011, 16'h0000, 16'h0000, 16'h0000, 12'h003, 4'h1);
    rd(16'h2023, 16'h000C, "chan_state");
    apply(16'h1000, 16'h0000, 16'h0000, 16'h0000, 12'h000, 4'h4);
    for (int s = 0; s < 4; s++) apply(16'h0000, 16'h0000, 16'h0002, 16'h0000, 12'h000, {2'h0, s[1:0]});
    $display("test corners done");
    wr(16'h2018, 16'hFFFF);
    rd(16'h2018, 16'h00FF, "mask_c");
    wr(16'h201B, 16'hFFFF);
    rd(16'h201B, 16'hFF00, "mask_f");
    wr(16'h2019, 16'hFFFF);
    rd(16'h2019, 16'h0000, "reserved_d");
    $display("test masks done");
    for (int t = 0; t < 40; t++) begin
      for (int j = 0; j < 5; j++) begin
        seed = lfsr_next(seed);
        r[j] = seed;
      end
      apply(r[0] & 16'h3333, r[1] & 16'h3333, r[2] & 16'h3333, r[3] & 16'h3333, r[4][11:0], r[4][15:12]);
    end
    $display("test random done");
    apply(16'h0000, 16'h0000, 16'h0000, 16'h0000, 12'h000, 4'h1);
    wr(16'h2022, 16'h0003);
    rd(16'h2020, 16'h0000, "status_clr");
    wr(16'h2021, 16'h0001);
    rd(16'h2021, 16'h0001, "enable");
    check("irq_idle", 16'h0000, {15'h0000, irq});
    apply(16'h0011, 16'h0000, 16'h0000, 16'h0000, 12'h000, 4'h1);
    check("irq_set", 16'h0001, {15'h0000, irq});
    rd(16'h2020, 16'h0003, "status");
    wr(16'h2022, 16'h0001);
    tick(2);
    check("irq_clr", 16'h0000, {15'h0000, irq});
    rd(16'h2020, 16'h0002, "status_kept");
    wr(16'h2021, 16'h0000);
    apply(16'h0000, 16'h0000, 16'h0000, 16'h0000, 12'h000, 4'h1);
    apply(16'h0011, 16'h0000, 16'h0000, 16'h0000, 12'h000, 4'h1);
    check("irq_mask", 16'h0000, {15'h0000, irq});
    rd(16'h2020, 16'h0003, "status_masked");
    $display("test interrupt done");
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(16'h2016, 16'h0300, "alloc_a_reset");
    rd(16'h2021, 16'h0000, "enable_reset");
    rd(16'h2020, 16'h0000, "status_reset");
    check("warn_reset", 16'h0000, {15'h0000, alloc_warning});
    $display("test mid reset done");
    report_and_stop;
  end
endmodule
